//--- toc_compare_units.sv
/*
  two output compare channels of a 16-bit timer with the shared high-byte
  latch, count-write blocking and pin override.
  assumes the counter, its ceiling/floor/direction and the cpu strobes come
  from outside, synchronous to mclk_i; tick_i is the timer clock enable.
*/
// Functional notes
// - compare full count each cycle, flag equality
// - two independent channels, A and B
// - match sets flag one timer tick later
// - enabled flag requests irq, cleared when serviced
// - writing one clears flag, zero ignored
// - waveform from match, mode, action, extremes
// - channel A compare usable as ceiling
// - double buffered in twelve PWM modes
// - buffer loads only at ceiling or floor
// - cpu reaches buffer or active register
// - value changes only on writes; direct read
// - high byte latched, low write moves both
// - force updates level, no flag, non-PWM
// - count write blocks next tick's matches
// - count written at ceiling loses that match
// - output level kept across mode changes
// - action setting applies at once, unbuffered
// - action selects next level and pin source
// - reset clears output levels to zero
// - nonzero action overrides port value
// - zero action leaves level unchanged
`timescale 1ns/1ps
`include "toc_map.svh"

module toc_compare_units (
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    tick_i,
  input  wire toc_pkg::toc_word_type   timer_count_i,
  input  wire logic                    count_top_i,
  input  wire logic                    count_floor_i,
  input  wire logic                    count_down_i,
  input  wire logic                    count_write_i,
  input  wire toc_pkg::toc_mode_type   waveform_mode_select_i,
  input  wire logic [7:0]              cpu_wdata_i,
  input  wire logic [1:0]              cmp_wr_high_i,
  input  wire logic [1:0]              cmp_wr_low_i,
  input  wire logic [1:0]              cmp_rd_high_i,
  input  wire logic [1:0]              cmp_rd_low_i,
  input  wire logic [1:0]              flag_clear_i,
  input  wire logic [1:0]              irq_ack_i,
  input  wire logic [1:0]              compare_irq_enable_i,
  input  wire toc_pkg::toc_action_type compare_output_action_a_i,
  input  wire toc_pkg::toc_action_type compare_output_action_b_i,
  input  wire logic [1:0]              force_compare_strobe_i,
  input  wire logic [1:0]              port_out_i,
  input  wire logic [1:0]              compare_pin_direction_i,
  output logic [7:0]                   cmp_rd_data_o,
  output logic [1:0]                   compare_match_flag_o,
  output logic [1:0]                   compare_irq_o,
  output logic [1:0]                   compare_output_level_o,
  output logic [1:0]                   match_o,
  output toc_pkg::toc_word_type        compare_a_ceiling_o,
  output logic [1:0]                   pin_out_o,
  output logic [1:0]                   pin_oe_o
);

  // ==========================================================
  // shared state
  logic [7:0]              temp_reg;
  logic                    block_reg;
  logic                    block_w;
  toc_pkg::toc_word_type   wr_value_w;
  toc_pkg::toc_action_type act_w [`TOC_NUM_CH];
  toc_pkg::toc_word_type   view_w [`TOC_NUM_CH];
  toc_pkg::toc_word_type   active_w [`TOC_NUM_CH];
  logic [1:0]              match_w;
  logic [1:0]              flag_w;
  logic [1:0]              level_w;

  assign act_w[0]   = compare_output_action_a_i;
  assign act_w[1]   = compare_output_action_b_i;
  assign wr_value_w = {temp_reg, cpu_wdata_i};

  // ==========================================================
  // high-byte latch, shared by both channels
  // a low write with no prior high write reuses whatever the latch holds
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      temp_reg <= 8'h00;
    else if (|cmp_wr_high_i)
      temp_reg <= cpu_wdata_i;
  end

  // ==========================================================
  // count-write blocking
  // held until a tick passes, so it works with the timer clock stopped
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      block_reg <= 1'h0;
    else if (count_write_i)
      block_reg <= 1'h1;
    else if (tick_i)
      block_reg <= 1'h0;
  end

  // the write cycle itself also blocks: a write overrides counting
  assign block_w = block_reg | count_write_i;

  // ==========================================================
  // channels
  genvar g;
  generate
    for (g = 0; g < `TOC_NUM_CH; g++)
    begin : g_ch
      toc_channel u_ch (
        .mclk_i        (mclk_i),
        .arst_n_i      (arst_n_i),
        .tick_i        (tick_i),
        .count_i       (timer_count_i),
        .count_top_i   (count_top_i),
        .count_floor_i (count_floor_i),
        .count_down_i  (count_down_i),
        .block_i       (block_w),
        .mode_i        (waveform_mode_select_i),
        .action_i      (act_w[g]),
        .flag_clear_i  (flag_clear_i[g]),
        .irq_ack_i     (irq_ack_i[g]),
        .force_i       (force_compare_strobe_i[g]),
        .wr_low_i      (cmp_wr_low_i[g]),
        .wr_value_i    (wr_value_w),
        .match_o       (match_w[g]),
        .flag_o        (flag_w[g]),
        .level_o       (level_w[g]),
        .active_o      (active_w[g]),
        .cpu_view_o    (view_w[g])
      );
    end
  endgenerate

  // ==========================================================
  // registered outputs
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      compare_match_flag_o   <= 2'h0;
      compare_irq_o          <= 2'h0;
      compare_output_level_o <= 2'h0;
      match_o                <= 2'h0;
    end
    else
    begin
      compare_match_flag_o   <= flag_w;
      compare_irq_o          <= flag_w & compare_irq_enable_i;
      compare_output_level_o <= level_w;
      match_o                <= match_w;
    end
  end

  // channel A's active value feeds the counter's ceiling compare
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      compare_a_ceiling_o <= `TOC_CMP_RST;
    else
      compare_a_ceiling_o <= active_w[0];
  end

  // ==========================================================
  // pin override
  // direction is never taken over; software must set it to see the level
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_out_o <= 2'h0;
      pin_oe_o  <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < `TOC_NUM_CH; i++)
      begin
        pin_out_o[i] <= (act_w[i] != `TOC_ACT_NONE) ? level_w[i] : port_out_i[i];
        pin_oe_o[i]  <= compare_pin_direction_i[i];
      end
    end
  end

  // ==========================================================
  // compare value read-back, no latch involved
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cmp_rd_data_o <= 8'h00;
    else if (cmp_rd_low_i[0])
      cmp_rd_data_o <= view_w[0][7:0];
    else if (cmp_rd_high_i[0])
      cmp_rd_data_o <= view_w[0][15:8];
    else if (cmp_rd_low_i[1])
      cmp_rd_data_o <= view_w[1][7:0];
    else if (cmp_rd_high_i[1])
      cmp_rd_data_o <= view_w[1][15:8];
  end

  // ==========================================================
  // checks
  sequence s_blocked_tick;
    count_write_i ##1 (tick_i && !count_write_i);
  endsequence

  sequence s_hi_lo_write;
    cmp_wr_high_i[0] ##1 cmp_wr_low_i[0] && !cmp_wr_high_i[0];
  endsequence

  block_match_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_blocked_tick |-> match_w == 2'h0)
    else $error("match not blocked after count write");

  pair_write_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_hi_lo_write |=> view_w[0] == {$past(cpu_wdata_i, 2), $past(cpu_wdata_i)})
    else $error("compare word not assembled from high then low");

  irq_gate_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ##1 compare_irq_o == ($past(flag_w) & $past(compare_irq_enable_i)))
    else $error("interrupt not gated by enable");

  pin_mux_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    act_w[0] != `TOC_ACT_NONE |=> pin_out_o[0] == $past(level_w[0]))
    else $error("pin not overridden by level");

  port_pass_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    act_w[1] == `TOC_ACT_NONE |=> pin_out_o[1] == $past(port_out_i[1]))
    else $error("port value not passed through");

  reset_level_a : assert property (@(posedge mclk_i)
    !arst_n_i |-> compare_output_level_o == 2'h0 && level_w == 2'h0)
    else $error("level not cleared by reset");

  ceiling_follow_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ##1 compare_a_ceiling_o == $past(active_w[0]))
    else $error("ceiling does not follow channel A");

  sequence s_stopped_write;
    count_write_i ##1 (!tick_i && !count_write_i);
  endsequence

  sequence s_match_tick;
    match_w[0] ##1 tick_i;
  endsequence

  write_blocks_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    count_write_i |-> match_w == 2'h0)
    else $error("match in the count write cycle");

  block_hold_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_stopped_write |=> block_reg)
    else $error("block lost with the timer stopped");

  match_tick_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    match_w != 2'h0 |-> tick_i)
    else $error("match without a timer tick");

  match_flag_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    s_match_tick |=> flag_w[0])
    else $error("flag not set one tick after match");

  flag_irq_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (compare_irq_o & ~compare_match_flag_o) == 2'h0)
    else $error("interrupt without its flag");

  latch_load_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cmp_wr_high_i != 2'h0 |=> temp_reg == $past(cpu_wdata_i))
    else $error("high byte not latched");

  latch_hold_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cmp_wr_high_i == 2'h0 |=> $stable(temp_reg))
    else $error("latch moved without high write");

  read_low_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cmp_rd_low_i[0] |=> cmp_rd_data_o == $past(view_w[0][7:0]))
    else $error("channel A low byte misread");

  read_high_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cmp_rd_high_i[0] && !cmp_rd_low_i[0] |=> cmp_rd_data_o == $past(view_w[0][15:8]))
    else $error("channel A high byte misread");

  read_b_low_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cmp_rd_low_i == 2'h2 && !cmp_rd_high_i[0] |=> cmp_rd_data_o == $past(view_w[1][7:0]))
    else $error("channel B low byte misread");

  read_hold_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (cmp_rd_low_i | cmp_rd_high_i) == 2'h0 |=> $stable(cmp_rd_data_o))
    else $error("read data moved without a read");

  pin_dir_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ##1 pin_oe_o == $past(compare_pin_direction_i))
    else $error("pin enable not from direction");

  pin_mux_b_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    act_w[1] != `TOC_ACT_NONE |=> pin_out_o[1] == $past(level_w[1]))
    else $error("pin B not overridden by level");

  port_keep_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    act_w[0] == `TOC_ACT_NONE |=> pin_out_o[0] == $past(port_out_i[0]))
    else $error("port A value not passed through");

endmodule : toc_compare_units

//--- toc_map.svh
/*
  constants of the timer compare units: widths, encodings, reset values.
  assumes it is included once per compilation unit through its guard.
*/
`ifndef TOC_MAP_SVH
`define TOC_MAP_SVH

`define TOC_CMP_W        16
`define TOC_BYTE_W       8
`define TOC_NUM_CH       2
`define TOC_CMP_RST      16'h0000
`define TOC_LEVEL_RST    1'h0
`define TOC_COUNT_MAX    16'hffff

`define TOC_ACT_NONE     2'h0
`define TOC_ACT_TOGGLE   2'h1
`define TOC_ACT_CLEAR    2'h2
`define TOC_ACT_SET      2'h3

`define TOC_MODE_NORMAL  4'h0
`define TOC_MODE_CTC_A   4'h4
`define TOC_MODE_CTC_CAP 4'hc
`define TOC_MODE_RSVD    4'hd

`endif

//--- toc_pkg.sv
/*
  types and mode decoding shared by the compare units.
  assumes toc_map.svh is on the include path.
*/
`include "toc_map.svh"

package toc_pkg;

  typedef logic [1:0]            toc_action_type;
  typedef logic [3:0]            toc_mode_type;
  typedef logic [`TOC_CMP_W-1:0] toc_word_type;

  // twelve modes double buffer; normal, both clear-on-match and reserved do not
  function automatic logic toc_is_pwm(input toc_mode_type m);
    return !(m == `TOC_MODE_NORMAL || m == `TOC_MODE_CTC_A ||
             m == `TOC_MODE_CTC_CAP || m == `TOC_MODE_RSVD);
  endfunction : toc_is_pwm

  // phase correct modes reload at the ceiling, the others at the floor
  function automatic logic toc_load_at_top(input toc_mode_type m);
    return (m == 4'h1 || m == 4'h2 || m == 4'h3 || m == 4'ha || m == 4'hb);
  endfunction : toc_load_at_top

  function automatic logic toc_is_fast(input toc_mode_type m);
    return (m == 4'h5 || m == 4'h6 || m == 4'h7 || m == 4'he || m == 4'hf);
  endfunction : toc_is_fast

endpackage : toc_pkg

//--- toc_channel.sv
/*
  one compare channel: active and buffered compare value, match, flag,
  internal output level.
  assumes one clock, tick_i as timer clock enable, counter outside.
*/
`timescale 1ns/1ps
`include "toc_map.svh"

module toc_channel (
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    tick_i,
  input  wire toc_pkg::toc_word_type   count_i,
  input  wire logic                    count_top_i,
  input  wire logic                    count_floor_i,
  input  wire logic                    count_down_i,
  input  wire logic                    block_i,
  input  wire toc_pkg::toc_mode_type   mode_i,
  input  wire toc_pkg::toc_action_type action_i,
  input  wire logic                    flag_clear_i,
  input  wire logic                    irq_ack_i,
  input  wire logic                    force_i,
  input  wire logic                    wr_low_i,
  input  wire toc_pkg::toc_word_type   wr_value_i,
  output logic                         match_o,
  output logic                         flag_o,
  output logic                         level_o,
  output toc_pkg::toc_word_type        active_o,
  output toc_pkg::toc_word_type        cpu_view_o
);

  // ==========================================================
  // compare
  toc_pkg::toc_word_type active_reg;
  toc_pkg::toc_word_type buf_reg;
  logic                  pend_reg;
  logic                  flag_reg;
  logic                  level_reg;
  logic                  level_next;
  logic                  pwm;
  logic                  load_now;
  logic                  flag_set;

  assign pwm      = toc_pkg::toc_is_pwm(mode_i);
  assign match_o  = tick_i & (count_i == active_reg) & ~block_i;
  assign load_now = pwm & tick_i &
                    (toc_pkg::toc_load_at_top(mode_i) ? count_top_i : count_floor_i);
  assign flag_set = tick_i & pend_reg;

  // ==========================================================
  // compare value storage
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      active_reg <= `TOC_CMP_RST;
      buf_reg    <= `TOC_CMP_RST;
    end
    else
    begin
      if (wr_low_i)
        buf_reg <= wr_value_i;
      if (wr_low_i && !pwm)
        active_reg <= wr_value_i;
      else if (load_now)
        active_reg <= buf_reg;
    end
  end

  assign cpu_view_o = pwm ? buf_reg : active_reg;
  assign active_o   = active_reg;

  // ==========================================================
  // flag: set one timer tick after the match, set beats clear
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pend_reg <= 1'h0;
      flag_reg <= 1'h0;
    end
    else
    begin
      if (tick_i)
        pend_reg <= match_o;
      if (flag_set)
        flag_reg <= 1'h1;
      else if (flag_clear_i || irq_ack_i)
        flag_reg <= 1'h0;
    end
  end

  assign flag_o = flag_reg;

  // ==========================================================
  // output level, untouched by mode changes
  always_comb
  begin
    level_next = level_reg;
    if (!pwm && (match_o || force_i))
    begin
      if (action_i == `TOC_ACT_TOGGLE)
        level_next = ~level_reg;
      else if (action_i == `TOC_ACT_CLEAR)
        level_next = 1'h0;
      else if (action_i == `TOC_ACT_SET)
        level_next = 1'h1;
    end
    else if (toc_pkg::toc_is_fast(mode_i) && action_i[1])
    begin
      if (match_o)
        level_next = ~action_i[0];
      else if (tick_i && count_top_i)
        level_next = action_i[0];
    end
    else if (pwm && action_i[1] && match_o)
      level_next = action_i[0] ^ count_down_i;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      level_reg <= `TOC_LEVEL_RST;
    else
      level_reg <= level_next;
  end

  assign level_o = level_reg;

  // ==========================================================
  // checks
  flag_late_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(flag_reg) |-> $past(pend_reg) && $past(tick_i))
    else $error("flag rose without a matched tick before");

  flag_clear_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (flag_clear_i || irq_ack_i) && !flag_set |=> !flag_reg)
    else $error("flag not cleared");

  force_flag_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    force_i && !pwm && action_i == `TOC_ACT_SET && !flag_set && !flag_clear_i && !irq_ack_i
      |=> level_reg && flag_reg == $past(flag_reg))
    else $error("force did not set level or touched flag");

  action_zero_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    action_i == `TOC_ACT_NONE |=> level_reg == $past(level_reg))
    else $error("level moved with no action");

  buffer_hold_a : assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    pwm && !load_now |=> active_reg == $past(active_reg))
    else $error("active compare changed off ceiling or floor");

endmodule : toc_channel

//--- toc_cpu_model.sv
/*
  cpu side of the compare units: byte-wide compare writes and reads.
  assumes strobes change on the falling edge of mclk_i, read data registered.
*/
`timescale 1ns/1ps

module toc_cpu_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] rd_data_i,
  output logic [7:0]      wdata_o,
  output logic [1:0]      wr_high_o,
  output logic [1:0]      wr_low_o,
  output logic [1:0]      rd_high_o,
  output logic [1:0]      rd_low_o
);
  // ==========
  // idle bus
  initial
  begin
    wdata_o = 8'h5a;
    wr_high_o = 2'h0;
    wr_low_o = 2'h0;
    rd_high_o = 2'h0;
    rd_low_o = 2'h0;
  end

  // ==========
  // transfers
  // high byte first: the low write moves the shared latch with it
  task automatic write16(input logic ch, input logic [15:0] v);
    @(negedge mclk_i);
    wdata_o = v[15:8];
    wr_high_o[ch] = 1'b1;
    @(negedge mclk_i);
    wr_high_o[ch] = 1'b0;
    wdata_o = v[7:0];
    wr_low_o[ch] = 1'b1;
    @(negedge mclk_i);
    wr_low_o[ch] = 1'b0;
    // a released bus must not look like the last byte
    wdata_o = ~v[7:0];
  endtask : write16

  task automatic read16(input logic ch, output logic [15:0] v);
    @(negedge mclk_i);
    rd_low_o[ch] = 1'b1;
    @(negedge mclk_i);
    rd_low_o[ch] = 1'b0;
    v[7:0] = rd_data_i;
    rd_high_o[ch] = 1'b1;
    @(negedge mclk_i);
    rd_high_o[ch] = 1'b0;
    v[15:8] = rd_data_i;
  endtask : read16

endmodule : toc_cpu_model

//--- test_toc_compare_units.sv
/*
  self-checking bench of the two compare channels.
  assumes toc_pkg, toc_compare_units and toc_cpu_model are compiled first.
*/
`timescale 1ns/1ps

module test_toc_compare_units;
  // ==========
  // signals
  logic        mclk_i, arst_n_i, tick_i, count_top_i, count_floor_i;
  logic        count_down_i, count_write_i;
  logic [15:0] timer_count_i, compare_a_ceiling_o, v, rd, cur;
  logic [3:0]  waveform_mode_select_i;
  logic [7:0]  cpu_wdata_i, cmp_rd_data_o;
  logic [1:0]  cmp_wr_high_i, cmp_wr_low_i, cmp_rd_high_i, cmp_rd_low_i, lv, a;
  logic [1:0]  flag_clear_i, irq_ack_i, compare_irq_enable_i, force_compare_strobe_i;
  logic [1:0]  compare_output_action_a_i, compare_output_action_b_i, port_out_i;
  logic [1:0]  compare_pin_direction_i, compare_match_flag_o, compare_irq_o;
  logic [1:0]  compare_output_level_o, match_o, pin_out_o, pin_oe_o;
  logic [1:0]  acts [6] = '{2'h2, 2'h3, 2'h1, 2'h1, 2'h0, 2'h1};
  logic [31:0] seed = 32'h63dda081;
  logic [31:0] r;
  int          err_count = 0;
  int          checks = 0;
  int          n, ma, fa;

  toc_compare_units toc_compare_units_i (
    .mclk_i, .arst_n_i, .tick_i, .timer_count_i, .count_top_i, .count_floor_i,
    .count_down_i, .count_write_i, .waveform_mode_select_i, .cpu_wdata_i,
    .cmp_wr_high_i, .cmp_wr_low_i, .cmp_rd_high_i, .cmp_rd_low_i, .flag_clear_i,
    .irq_ack_i, .compare_irq_enable_i, .compare_output_action_a_i,
    .compare_output_action_b_i, .force_compare_strobe_i, .port_out_i,
    .compare_pin_direction_i, .cmp_rd_data_o, .compare_match_flag_o, .compare_irq_o,
    .compare_output_level_o, .match_o, .compare_a_ceiling_o, .pin_out_o, .pin_oe_o
  );

  toc_cpu_model toc_cpu_model_i (
    .mclk_i, .rd_data_i(cmp_rd_data_o), .wdata_o(cpu_wdata_i), .wr_high_o(cmp_wr_high_i),
    .wr_low_o(cmp_wr_low_i), .rd_high_o(cmp_rd_high_i), .rd_low_o(cmp_rd_low_i)
  );

  // ==========
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction : rnd

  function automatic logic pwm(input logic [3:0] m);
    return !(m inside {4'h0, 4'h4, 4'hc, 4'hd});
  endfunction : pwm

  function automatic logic at_top(input logic [3:0] m);
    return m inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
  endfunction : at_top

  function automatic logic nx(input logic [1:0] act, input logic l);
    return (act == 2'h1) ? ~l : (act == 2'h0) ? l : act[0];
  endfunction : nx

  task automatic cyc(input int c);
    repeat (c) @(negedge mclk_i);
  endtask : cyc

  task automatic set_act(input int ch, input logic [1:0] act);
    if (ch == 0)
      compare_output_action_a_i = act;
    else
      compare_output_action_b_i = act;
  endtask : set_act

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ==========
  // clock, watchdog
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  initial
  begin
    #200000;
    err_count++;
    results();
  end

  // ==========
  // tests
  initial
  begin
    arst_n_i = 1'b0;
    tick_i = 1'b1;
    timer_count_i = 16'hffff;
    count_top_i = 1'b0;
    count_floor_i = 1'b0;
    count_down_i = 1'b0;
    count_write_i = 1'b0;
    waveform_mode_select_i = 4'h0;
    flag_clear_i = 2'h0;
    irq_ack_i = 2'h0;
    compare_irq_enable_i = 2'h0;
    compare_output_action_a_i = 2'h0;
    compare_output_action_b_i = 2'h0;
    force_compare_strobe_i = 2'h0;
    port_out_i = 2'h0;
    compare_pin_direction_i = 2'h0;
    cyc(10);
    arst_n_i = 1'b1;
    cyc(1);
    chk("reset level", 0, compare_output_level_o);
    for (int ch = 0; ch < 2; ch++)
    begin
      r = rnd();
      v = {1'b0, r[14:0]};
      cur = (ch == 0) ? v : cur;
      toc_cpu_model_i.write16(ch[0], v);
      toc_cpu_model_i.read16(ch[0], rd);
      chk("readback", v, rd);
    end
    chk("ceiling", cur, compare_a_ceiling_o);
    $display("test write done");
    // last round in a pwm mode, where the strobe must do nothing
    lv = 2'h0;
    for (int ch = 0; ch < 2; ch++)
      for (int k = 0; k < 6; k++)
      begin
        r = rnd();
        a = acts[k];
        waveform_mode_select_i = (k == 5) ? 4'h5 : 4'h0;
        set_act(ch, a);
        port_out_i = r[1:0];
        compare_pin_direction_i = (k == 0) ? 2'h0 : r[3:2];
        force_compare_strobe_i[ch] = 1'b1;
        cyc(1);
        force_compare_strobe_i = 2'h0;
        cyc(2);
        lv[ch] = (k < 5) ? nx(a, lv[ch]) : lv[ch];
        chk("forced level", lv, compare_output_level_o);
        chk("forced flag", 0, compare_match_flag_o);
        chk("pin", (a != 2'h0) ? lv[ch] : r[ch], pin_out_o[ch]);
        chk("pin oe", compare_pin_direction_i, pin_oe_o);
      end
    $display("test force done");
    set_act(0, 2'h0);
    set_act(1, 2'h0);
    for (int m = 0; m < 16; m++)
    begin
      waveform_mode_select_i = m[3:0];
      r = rnd();
      v = {1'b0, r[14:0]};
      toc_cpu_model_i.write16(1'b0, v);
      toc_cpu_model_i.read16(1'b0, rd);
      chk("cpu view", v, rd);
      chk("unloaded", pwm(m[3:0]) ? cur : v, compare_a_ceiling_o);
      count_top_i = ~at_top(m[3:0]);
      count_floor_i = at_top(m[3:0]);
      cyc(1);
      count_top_i = ~count_top_i;
      count_floor_i = ~count_floor_i;
      cyc(1);
      chk("early load", pwm(m[3:0]) ? cur : v, compare_a_ceiling_o);
      count_top_i = 1'b0;
      count_floor_i = 1'b0;
      cyc(2);
      chk("load", v, compare_a_ceiling_o);
      cur = v;
    end
    chk("kept level", lv, compare_output_level_o);
    $display("test buffer done");
    waveform_mode_select_i = 4'h4;
    compare_irq_enable_i = 2'h1;
    set_act(0, 2'h1);
    set_act(1, 2'h1);
    for (int ch = 0; ch < 2; ch++)
    begin
      r = rnd();
      v = {1'b0, ch[0], r[13:0]};
      cur = (ch == 0) ? v : cur;
      toc_cpu_model_i.write16(ch[0], v);
      timer_count_i = v;
      cyc(1);
      timer_count_i = 16'hffff;
      n = 0;
      ma = 0;
      fa = 0;
      for (int k = 1; k < 6; k++)
      begin
        if (match_o[ch] === 1'b1)
        begin
          n++;
          ma = (ma == 0) ? k : ma;
        end
        if (fa == 0 && compare_match_flag_o[ch] === 1'b1)
          fa = k;
        cyc(1);
      end
      lv[ch] = ~lv[ch];
      chk("matches", 1, n);
      chk("flag delay", ma + 2, fa);
      chk("other flag", 0, compare_match_flag_o[1-ch]);
      chk("toggle", lv, compare_output_level_o);
      chk("irq", (ch == 0), compare_irq_o[ch]);
      irq_ack_i[0] = (ch == 0);
      flag_clear_i[1] = (ch == 1);
      cyc(1);
      irq_ack_i = 2'h0;
      flag_clear_i = 2'h0;
      cyc(2);
      chk("cleared", 0, compare_match_flag_o);
    end
    $display("test match done");
    // count written equal to the compare value while the timer is stopped;
    // channel A runs as the variable ceiling in mode 15
    for (int ch = 0; ch < 2; ch++)
    begin
      waveform_mode_select_i = (ch == 0) ? 4'hf : 4'h4;
      tick_i = 1'b0;
      timer_count_i = (ch == 0) ? cur : v;
      count_write_i = 1'b1;
      cyc(1);
      count_write_i = 1'b0;
      tick_i = 1'b1;
      cyc(1);
      timer_count_i = 16'hffff;
      n = 0;
      for (int k = 0; k < 5; k++)
      begin
        n += int'(match_o[ch] === 1'b1);
        cyc(1);
      end
      chk("blocked", 0, n);
    end
    chk("blocked flag", 0, compare_match_flag_o);
    $display("test block done");
    // fast pwm on channel B: action 2 sets on match, clears at the ceiling
    waveform_mode_select_i = 4'h5;
    for (int k = 2; k < 4; k++)
    begin
      set_act(1, k[1:0]);
      timer_count_i = v;
      cyc(1);
      timer_count_i = 16'hffff;
      cyc(2);
      chk("pwm match", (k == 2), compare_output_level_o[1]);
      count_top_i = 1'b1;
      cyc(1);
      count_top_i = 1'b0;
      cyc(2);
      chk("pwm top", (k == 3), compare_output_level_o[1]);
    end
    // dual slope: action 2 clears on an upcount match, sets on a downcount one
    waveform_mode_select_i = 4'h1;
    set_act(1, 2'h2);
    for (int k = 0; k < 2; k++)
    begin
      count_down_i = k[0];
      timer_count_i = v;
      cyc(1);
      timer_count_i = 16'hffff;
      cyc(2);
      chk("dual slope", (k == 1), compare_output_level_o[1]);
    end
    count_down_i = 1'b0;
    $display("test pwm done");
    results();
  end

endmodule : test_toc_compare_units
